// >>> hw/timer_defs.svh
// register offsets, field positions, reset values and command codes of the timer control block
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define ADDR_WIDTH 8
`define DATA_WIDTH 16

`define OFS_RUN_CONTROL 8'h00
`define OFS_WAVEFORM_MODE_CONTROL 8'h01
`define OFS_FORCED_OUTPUT_VALUES 8'h02
`define OFS_SPLIT_REGISTER 8'h03
`define OFS_CONTROL_CLEAR 8'h04
`define OFS_CONTROL_SET 8'h05
`define OFS_VALID_CLEAR 8'h06
`define OFS_VALID_SET 8'h07
`define OFS_COUNT 8'h20
`define OFS_PERIOD 8'h26
`define OFS_COMPARE0 8'h28
`define OFS_COMPARE1 8'h2a
`define OFS_COMPARE2 8'h2c
`define OFS_PERIOD_BUFFER 8'h36
`define OFS_COMPARE_BUFFER0 8'h38
`define OFS_COMPARE_BUFFER1 8'h3a
`define OFS_COMPARE_BUFFER2 8'h3c

`define BIT_RUN_ENABLE 0
`define BIT_AUTO_LOCK 3
`define POS_OUTPUT_ENABLE 4
`define POS_WAVEFORM_MODE 0
`define POS_FORCED_VALUE 0
`define BIT_SPLIT_SELECT 0
`define BIT_DIRECTION 0
`define BIT_LOCK_UPDATE 1
`define POS_COMMAND 2
`define POS_VALID 0

`define CHANNELS 3
`define VALID_BITS 4
`define COMMAND_NONE 2'h0
`define COMMAND_UPDATE 2'h1
`define COMMAND_RESTART 2'h2
`define COMMAND_HARD_RESET 2'h3

`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define HALF_WIDTH 8

`endif

// >>> hw/timer_pkg.sv
// shared types of the timer control block
package timer_pkg;

   typedef enum logic [2:0] {
      normal_mode = 3'h0,
      frequency_mode = 3'h1,
      reserved2_mode = 3'h2,
      single_slope_mode = 3'h3,
      reserved4_mode = 3'h4,
      dual_slope_top_mode = 3'h5,
      dual_slope_both_mode = 3'h6,
      dual_slope_bottom_mode = 3'h7
   } waveform_mode_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_request_type;

   typedef struct packed {
      logic run;
      logic [2:0] channel_output_enable;
      logic auto_lock;
      waveform_mode_type waveform_mode;
      logic [2:0] forced_output_value;
      logic split_select;
      logic lock_update;
      logic dir;
      logic [3:0] buffer_valid;
      logic [15:0] period_buffer;
      logic [2:0][15:0] compare_buffer;
      logic [15:0] period;
      logic [2:0][15:0] compare_register;
      logic [15:0] rdata;
   } control_state_type;

   typedef struct packed {
      logic [15:0] count;
      logic update_event;
      logic overflow_event;
   } counter_state_type;

   typedef struct packed {
      logic [2:0] level;
      logic [2:0] pin_out;
      logic [2:0] pin_override;
   } waveform_state_type;

endpackage : timer_pkg

// >>> hw/timer_counter_core.sv
// counting sequence, update and overflow points of the timer
`timescale 1ns/1ps
module timer_counter_core #(
   parameter int counter_width = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic split_select,
   input wire timer_pkg::waveform_mode_type waveform_mode,
   input wire logic dir,
   input wire logic [counter_width-1:0] top,
   input wire logic restart,
   input wire logic hard_reset,
   output logic [counter_width-1:0] count,
   output logic update_event,
   output logic overflow_event,
   output logic turn_down,
   output logic turn_up
);
   import timer_pkg::*;

   localparam int half = counter_width / 2;

   // split mode needs two equal halves
   if (counter_width < 4 || counter_width % 2 != 0) begin : g_width_check
      $error("counter_width must be even and at least 4");
   end

   counter_state_type q;
   counter_state_type d;
   logic dual;
   logic at_top;
   logic at_bottom;

   assign dual = waveform_mode inside {dual_slope_top_mode, dual_slope_both_mode, dual_slope_bottom_mode};
   assign at_top = (q.count == top);
   assign at_bottom = (q.count == '0);
   // combinational so the direction bit turns in the same cycle as the peak
   assign turn_down = run && !split_select && dual && !dir && at_top;
   assign turn_up = run && !split_select && dual && dir && at_bottom;

   always_comb begin
      d = q;
      d.update_event = 1'b0;
      d.overflow_event = 1'b0;
      if (restart || hard_reset) begin
         d.count = '0;
      end else if (run && split_select) begin
         // two independent halves, each counting down from its own period byte
         d.count[half-1:0] = (q.count[half-1:0] == '0) ? top[half-1:0] : q.count[half-1:0] - 1'b1;
         d.count[counter_width-1:half] = (q.count[counter_width-1:half] == '0) ?
            top[counter_width-1:half] : q.count[counter_width-1:half] - 1'b1;
         d.overflow_event = (q.count[half-1:0] == '0);
      end else if (run) begin
         if (dual) begin
            if (!dir) begin
               d.count = at_top ? q.count - 1'b1 : q.count + 1'b1;
            end else begin
               d.count = at_bottom ? q.count + 1'b1 : q.count - 1'b1;
            end
            d.update_event = dir && at_bottom;
            unique case (waveform_mode)
               dual_slope_top_mode: d.overflow_event = !dir && at_top;
               dual_slope_both_mode: d.overflow_event = (!dir && at_top) || (dir && at_bottom);
               default: d.overflow_event = dir && at_bottom;
            endcase
         end else begin
            if (!dir) begin
               d.count = at_top ? '0 : q.count + 1'b1;
            end else begin
               d.count = at_bottom ? top : q.count - 1'b1;
            end
            if (waveform_mode == single_slope_mode) begin
               d.update_event = at_bottom;
               d.overflow_event = at_bottom;
            end else begin
               d.update_event = dir ? at_bottom : at_top;
               d.overflow_event = dir ? at_bottom : at_top;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign count = q.count;
   assign update_event = q.update_event;
   assign overflow_event = q.overflow_event;

endmodule : timer_counter_core

// >>> hw/waveform_generator.sv
// compare channels, forced levels and pin or logic routing of the waveform outputs
`timescale 1ns/1ps
`include "timer_defs.svh"
module waveform_generator (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire timer_pkg::waveform_mode_type waveform_mode,
   input wire logic dir,
   input wire logic [15:0] count,
   input wire logic [2:0][15:0] compare_register,
   input wire logic [2:0] forced_output_value,
   input wire logic [2:0] channel_output_enable,
   input wire logic [2:0] port_value,
   output logic [2:0] pin_out,
   output logic [2:0] pin_override,
   output logic [2:0] logic_out
);
   import timer_pkg::*;

   waveform_state_type q;
   waveform_state_type d;
   logic [2:0] level_next;
   logic [2:0] override_next;

   genvar i;
   generate
      for (i = 0; i < `CHANNELS; i++) begin : g_channel
         logic match;
         assign match = (count == compare_register[i]);
         always_comb begin
            level_next[i] = q.level[i];
            if (!run) begin
               level_next[i] = forced_output_value[i];
            end else begin
               unique case (waveform_mode)
                  frequency_mode: level_next[i] = match ? !q.level[i] : q.level[i];
                  single_slope_mode: level_next[i] = match ? 1'b0 : ((count == '0) ? 1'b1 : q.level[i]);
                  dual_slope_top_mode, dual_slope_both_mode, dual_slope_bottom_mode:
                     level_next[i] = match ? dir : q.level[i];
                  default: level_next[i] = q.level[i];
               endcase
            end
         end
         // normal mode makes no waveform, but a stopped timer still forces its level
         assign override_next[i] = channel_output_enable[i] && (!run || waveform_mode != normal_mode);
      end
   endgenerate

   always_comb begin
      d = q;
      d.level = level_next;
      d.pin_override = override_next;
      for (int n = 0; n < `CHANNELS; n++) begin
         d.pin_out[n] = override_next[n] ? level_next[n] : port_value[n];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pin_out = q.pin_out;
   assign pin_override = q.pin_override;
   assign logic_out = q.level;

endmodule : waveform_generator

// >>> hw/timer_waveform_control.sv
// control registers, buffered update and lock logic of the 16-bit timer with waveform outputs
`timescale 1ns/1ps
`include "timer_defs.svh"
module timer_waveform_control (
   input wire logic clk,
   input wire logic rst_n,
   input wire timer_pkg::reg_request_type reg_req,
   output logic [15:0] rdata,
   input wire logic [2:0] port_value,
   output logic [2:0] pin_out,
   output logic [2:0] pin_override,
   output logic [2:0] logic_out,
   output logic [15:0] count,
   output logic update_event,
   output logic overflow_event
);
   import timer_pkg::*;

   control_state_type q;
   control_state_type d;
   logic [15:0] top;
   logic turn_down;
   logic turn_up;
   logic command_write;
   logic [1:0] command;
   logic force_update;
   logic restart;
   logic hard_reset;
   logic transfer;
   logic all_valid;

   // read view of a control register; reused for both halves of the set/clear pairs
   function automatic logic [15:0] read_value(input control_state_type s, input logic [7:0] addr,
                                              input logic [15:0] cnt);
      logic [15:0] v;
      v = `RESET_WORD;
      unique case (addr)
         `OFS_RUN_CONTROL: v[`BIT_RUN_ENABLE] = s.run;
         `OFS_WAVEFORM_MODE_CONTROL: begin
            v[`POS_OUTPUT_ENABLE +: `CHANNELS] = s.channel_output_enable;
            v[`BIT_AUTO_LOCK] = s.auto_lock;
            v[`POS_WAVEFORM_MODE +: 3] = s.waveform_mode;
         end
         `OFS_FORCED_OUTPUT_VALUES: v[`POS_FORCED_VALUE +: `CHANNELS] = s.forced_output_value;
         `OFS_SPLIT_REGISTER: v[`BIT_SPLIT_SELECT] = s.split_select;
         // command field always reads zero
         `OFS_CONTROL_CLEAR, `OFS_CONTROL_SET: begin
            v[`BIT_LOCK_UPDATE] = s.lock_update;
            v[`BIT_DIRECTION] = s.dir;
         end
         `OFS_VALID_CLEAR, `OFS_VALID_SET: v[`POS_VALID +: `VALID_BITS] = s.buffer_valid;
         `OFS_COUNT: v = cnt;
         `OFS_PERIOD: v = s.period;
         `OFS_COMPARE0: v = s.compare_register[0];
         `OFS_COMPARE1: v = s.compare_register[1];
         `OFS_COMPARE2: v = s.compare_register[2];
         `OFS_PERIOD_BUFFER: v = s.period_buffer;
         `OFS_COMPARE_BUFFER0: v = s.compare_buffer[0];
         `OFS_COMPARE_BUFFER1: v = s.compare_buffer[1];
         `OFS_COMPARE_BUFFER2: v = s.compare_buffer[2];
         default: v = `RESET_WORD;
      endcase
      return v;
   endfunction : read_value

   function automatic logic is_write(input reg_request_type r, input logic [7:0] addr);
      return r.wr && (r.addr == addr);
   endfunction : is_write

   // frequency mode takes its top from compare channel 0
   assign top = (q.waveform_mode == frequency_mode) ? q.compare_register[0] : q.period;

   assign command_write = is_write(reg_req, `OFS_CONTROL_CLEAR) || is_write(reg_req, `OFS_CONTROL_SET);
   assign command = reg_req.wdata[`POS_COMMAND +: 2];
   assign force_update = command_write && (command == `COMMAND_UPDATE);
   assign restart = command_write && (command == `COMMAND_RESTART);
   assign hard_reset = command_write && (command == `COMMAND_HARD_RESET) && !q.run;

   // forced update ignores the lock; the timed one honours it
   assign transfer = force_update || (update_event && !q.lock_update);

   // channels that are not enabled never hold the lock
   always_comb begin
      all_valid = 1'b1;
      for (int n = 0; n < `CHANNELS; n++) begin
         if (q.channel_output_enable[n] && !q.buffer_valid[n + 1]) begin
            all_valid = 1'b0;
         end
      end
   end

   always_comb begin
      d = q;

      // plain read/write control registers
      if (is_write(reg_req, `OFS_RUN_CONTROL)) begin
         d.run = reg_req.wdata[`BIT_RUN_ENABLE];
      end
      if (is_write(reg_req, `OFS_WAVEFORM_MODE_CONTROL)) begin
         d.channel_output_enable = reg_req.wdata[`POS_OUTPUT_ENABLE +: `CHANNELS];
         d.auto_lock = reg_req.wdata[`BIT_AUTO_LOCK];
         d.waveform_mode = waveform_mode_type'(reg_req.wdata[`POS_WAVEFORM_MODE +: 3]);
      end
      if (is_write(reg_req, `OFS_FORCED_OUTPUT_VALUES)) begin
         d.forced_output_value = reg_req.wdata[`POS_FORCED_VALUE +: `CHANNELS];
      end
      if (is_write(reg_req, `OFS_SPLIT_REGISTER)) begin
         d.split_select = reg_req.wdata[`BIT_SPLIT_SELECT];
      end

      // software clear of lock and direction: zero bits leave state alone
      if (is_write(reg_req, `OFS_CONTROL_CLEAR)) begin
         if (reg_req.wdata[`BIT_LOCK_UPDATE]) begin
            d.lock_update = 1'b0;
         end
         if (reg_req.wdata[`BIT_DIRECTION]) begin
            d.dir = 1'b0;
         end
      end

      // auto-lock releases the lock once the compare buffer of every enabled channel holds a new value; the period buffer is not checked
      if (q.auto_lock && q.lock_update && all_valid) begin
         d.lock_update = 1'b0;
      end

      if (is_write(reg_req, `OFS_CONTROL_SET)) begin
         if (reg_req.wdata[`BIT_LOCK_UPDATE]) begin
            d.lock_update = 1'b1;
         end
         if (reg_req.wdata[`BIT_DIRECTION]) begin
            d.dir = 1'b1;
         end
      end

      // after the released lock sees its update it locks again; hardware set wins
      if (q.auto_lock && !q.lock_update && update_event) begin
         d.lock_update = 1'b1;
      end

      // hardware reversal in dual slope overrides a same-cycle software set or clear of dir; a restart command still wins
      if (turn_down) begin
         d.dir = 1'b1;
      end
      if (turn_up) begin
         d.dir = 1'b0;
      end

      // buffer-valid flags: update clear, software clear, software set, buffer write set; sets win
      if (transfer) begin
         d.period = q.period_buffer;
         d.compare_register = q.compare_buffer;
         d.buffer_valid = '0;
      end
      if (is_write(reg_req, `OFS_VALID_CLEAR)) begin
         d.buffer_valid = d.buffer_valid & ~reg_req.wdata[`POS_VALID +: `VALID_BITS];
      end
      if (is_write(reg_req, `OFS_VALID_SET)) begin
         d.buffer_valid = d.buffer_valid | reg_req.wdata[`POS_VALID +: `VALID_BITS];
      end
      // a buffer written in the transfer cycle keeps the new word and its valid flag
      if (is_write(reg_req, `OFS_PERIOD_BUFFER)) begin
         d.period_buffer = reg_req.wdata;
         d.buffer_valid[0] = 1'b1;
      end
      if (is_write(reg_req, `OFS_PERIOD)) begin
         d.period = reg_req.wdata;
      end
      for (int n = 0; n < `CHANNELS; n++) begin
         if (is_write(reg_req, `OFS_COMPARE_BUFFER0 + 8'(2 * n))) begin
            d.compare_buffer[n] = reg_req.wdata;
            d.buffer_valid[n + 1] = 1'b1;
         end
         if (is_write(reg_req, `OFS_COMPARE0 + 8'(2 * n))) begin
            d.compare_register[n] = reg_req.wdata;
         end
      end

      // restart also brings the count direction back to up
      if (restart) begin
         d.dir = 1'b0;
      end

      // hard reset returns every control and data register to its reset value
      if (hard_reset) begin
         d = '0;
      end

      // read data stand only in the cycle after the strobe
      d.rdata = reg_req.rd ? read_value(q, reg_req.addr, count) : `RESET_WORD;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rdata = q.rdata;

   timer_counter_core #(
      .counter_width(`DATA_WIDTH)
   ) u_core (
      .clk(clk),
      .rst_n(rst_n),
      .run(q.run),
      .split_select(q.split_select),
      .waveform_mode(q.waveform_mode),
      .dir(q.dir),
      .top(top),
      .restart(restart),
      .hard_reset(hard_reset),
      .count(count),
      .update_event(update_event),
      .overflow_event(overflow_event),
      .turn_down(turn_down),
      .turn_up(turn_up)
   );

   // pin direction is the port's job; the pin override only replaces the output value
   waveform_generator u_wave (
      .clk(clk),
      .rst_n(rst_n),
      .run(q.run),
      .waveform_mode(q.waveform_mode),
      .dir(q.dir),
      .count(count),
      .compare_register(q.compare_register),
      .forced_output_value(q.forced_output_value),
      .channel_output_enable(q.channel_output_enable),
      .port_value(port_value),
      .pin_out(pin_out),
      .pin_override(pin_override),
      .logic_out(logic_out)
   );

endmodule : timer_waveform_control

// >>> verif/timer_monitor.sv
// port-level assertion checker of the timer control block
`timescale 1ns/1ps
module timer_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire timer_pkg::reg_request_type reg_req,
   input wire logic [15:0] rdata,
   input wire logic [2:0] port_value,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_override,
   input wire logic [2:0] logic_out,
   input wire logic [15:0] count,
   input wire logic update_event,
   input wire logic overflow_event
);
   import timer_pkg::*;
   // shadow of run bit and forced levels, seen only through the bus
   logic [3:0] shadow_reg;
   logic [3:0] shadow_next;
   logic cmd_wr;
   assign cmd_wr = reg_req.wr && reg_req.addr[7:1] == 7'h02;
   always_comb begin
      shadow_next = shadow_reg;
      if (reg_req.wr && reg_req.addr == 8'h00) begin
         shadow_next[3] = reg_req.wdata[0];
      end
      if (reg_req.wr && reg_req.addr == 8'h02) begin
         shadow_next[2:0] = reg_req.wdata[2:0];
      end
      if (cmd_wr && reg_req.wdata[3:2] == 2'h3 && !shadow_reg[3]) begin
         shadow_next = 4'h0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_reg <= 4'h0;
      end else begin
         shadow_reg <= shadow_next;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence ctrl_read;
      reg_req.rd && reg_req.addr[7:3] == 5'h00;
   endsequence
   sequence settled_stop;
      (!shadow_reg[3] && $stable(shadow_reg))[*3];
   endsequence
   rdata_idle_a: assert property (!$past(reg_req.rd) |-> rdata == 16'h0000)
      else $error("read data not zero outside an answer");
   ctrl_upper_a: assert property (ctrl_read |=> rdata[15:7] == 9'h000)
      else $error("reserved control bits read nonzero");
   cmd_zero_a: assert property (ctrl_read ##0 reg_req.addr[2:1] == 2'h2 |=> rdata[3:2] == 2'h0)
      else $error("command field read nonzero");
   unmapped_zero_a: assert property (reg_req.rd && reg_req.addr == 8'h10 |=> rdata == 16'h0000)
      else $error("unmapped read nonzero");
   stopped_count_a: assert property (!shadow_reg[3] && !cmd_wr && !$past(cmd_wr) |=> $stable(count))
      else $error("count moved while stopped");
   stopped_quiet_a: assert property (!shadow_reg[3] |=> !update_event && !overflow_event)
      else $error("event pulse while stopped");
   pin_follow_a: assert property ($past(rst_n, 2)
      |-> (pin_out & ~pin_override) == ($past(port_value) & ~pin_override))
      else $error("pin without override lost port value");
   logic_pin_a: assert property (((pin_out ^ logic_out) & pin_override) == 3'h0)
      else $error("overridden pin differs from logic output");
   forced_level_a: assert property (settled_stop |-> logic_out == shadow_reg[2:0])
      else $error("stopped level not forced value");
endmodule : timer_monitor
bind timer_waveform_control timer_monitor i_monitor (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
   .rdata(rdata), .port_value(port_value), .pin_out(pin_out), .pin_override(pin_override),
   .logic_out(logic_out), .count(count), .update_event(update_event), .overflow_event(overflow_event));

// >>> verif/port_model.sv
// port pins: own output values and pin directions around the waveform outputs
`timescale 1ns/1ps
module port_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] pin_out,
   output logic [2:0] port_value,
   output logic [2:0] pad_level
);
   logic [2:0] dir_out_reg;
   logic [2:0] pattern_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_out_reg <= 3'h7;
         pattern_reg <= 3'h5;
      end else begin
         pattern_reg <= {pattern_reg[1:0], pattern_reg[2] ^ pattern_reg[1]};
      end
   end
   // changes every cycle so a stale port value cannot pass
   assign port_value = pattern_reg;
   // input pins float high on pull-ups
   assign pad_level = (pin_out & dir_out_reg) | ~dir_out_reg;
endmodule : port_model

// >>> verif/timer_waveform_control_bench.sv
// self-checking bench of the timer control block
`timescale 1ns/1ps
`define CK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module timer_waveform_control_bench;
   import timer_pkg::*;
   localparam logic [15:0] per = 16'h0009;
   localparam logic [15:0] cmp0 = 16'h0004;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   reg_request_type reg_req = '0;
   logic [15:0] rdata;
   logic [15:0] count;
   logic [2:0] port_value;
   logic [2:0] pin_out;
   logic [2:0] pin_override;
   logic [2:0] logic_out;
   logic [2:0] pad_level;
   logic update_event;
   logic overflow_event;
   int seed = 32'h2a08833b;
   int checks = 0;
   int miscompares = 0;
   int cycles = 0;
   logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
   timer_waveform_control i_dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .rdata(rdata),
      .port_value(port_value), .pin_out(pin_out), .pin_override(pin_override),
      .logic_out(logic_out), .count(count), .update_event(update_event), .overflow_event(overflow_event));
   port_model i_port (.clk(clk), .rst_n(rst_n), .pin_out(pin_out), .port_value(port_value),
      .pad_level(pad_level));
   always #2.5 clk = ~clk;
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic w(input logic [7:0] a, input logic [15:0] d);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      reg_req.wr <= 1'b0;
      @(posedge clk);
   endtask : w
   task automatic r(input logic [7:0] a, output logic [15:0] d);
      reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      reg_req.rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask : r
   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      r(a, d);
      `CK(d, e)
   endtask : rc
   // pulses in a window that is a whole number of counting periods
   function automatic logic [31:0] expect_events(input logic [2:0] m, input logic [15:0] n);
      logic [15:0] cyc;
      cyc = (m == 3'h1) ? cmp0 + 16'h1 : (m >= 3'h5) ? 16'(2 * per) : per + 16'h1;
      return {16'(n / cyc), 16'((m == 3'h6 ? 2 : 1) * n / cyc)};
   endfunction : expect_events
   task automatic ev(input logic [2:0] m, input logic [15:0] n);
      logic [15:0] u;
      logic [15:0] o;
      w(8'h01, {13'h0000, m});
      w(8'h05, 16'h0008);
      w(8'h00, 16'h0001);
      u = 16'h0;
      o = 16'h0;
      repeat (20) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         u += update_event;
         o += overflow_event;
      end
      w(8'h00, 16'h0000);
      `CK({u, o}, expect_events(m, n))
      $display("mode %0d done", m);
   endtask : ev
   initial begin
      logic [15:0] c1;
      logic [15:0] c2;
      logic [15:0] d;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 8; a++) rc(8'(a), 16'h0000);
      w(8'h10, 16'hffff);
      rc(8'h10, 16'h0000);
      repeat (4) begin
         d = 16'($random(seed));
         w(8'h01, d);
         rc(8'h01, d & 16'h007f);
         w(8'h02, d);
         rc(8'h02, d & 16'h0007);
         w(8'h03, d);
         rc(8'h03, d & 16'h0001);
      end
      w(8'h01, 16'h0000);
      w(8'h03, 16'h0000);
      w(8'h05, 16'h00f3);
      rc(8'h05, 16'h0003);
      w(8'h04, 16'h0001);
      rc(8'h04, 16'h0002);
      w(8'h04, 16'h0000);
      rc(8'h05, 16'h0002);
      w(8'h04, 16'h0002);
      w(8'h07, 16'h00f5);
      rc(8'h06, 16'h0005);
      w(8'h06, 16'h0001);
      rc(8'h07, 16'h0004);
      $display("bits done");
      // buffers hold the same values so update transfers change nothing
      w(8'h36, per);
      w(8'h38, cmp0);
      w(8'h26, per);
      w(8'h28, cmp0);
      w(8'h00, 16'h0001);
      r(8'h20, c1);
      r(8'h20, c2);
      `CK(c2, (c1 + 16'h2) % (per + 16'h1))
      w(8'h05, 16'h0001);
      r(8'h20, c1);
      r(8'h20, c2);
      `CK(c2, (c1 + per - 16'h1) % (per + 16'h1))
      w(8'h00, 16'h0000);
      r(8'h20, c1);
      r(8'h20, c2);
      `CK(c2, c1)
      $display("count done");
      foreach (modes[i]) ev(modes[i], 16'd180);
      w(8'h01, 16'h0000);
      w(8'h05, 16'h000a);
      w(8'h36, 16'h0007);
      rc(8'h06, 16'h0001);
      w(8'h00, 16'h0001);
      repeat (30) @(posedge clk);
      w(8'h00, 16'h0000);
      rc(8'h26, per);
      rc(8'h05, 16'h0002);
      w(8'h05, 16'h0004);
      rc(8'h26, 16'h0007);
      rc(8'h06, 16'h0000);
      w(8'h04, 16'h0002);
      w(8'h38, 16'h0003);
      w(8'h00, 16'h0001);
      repeat (30) @(posedge clk);
      w(8'h00, 16'h0000);
      rc(8'h28, 16'h0003);
      rc(8'h06, 16'h0000);
      $display("lock done");
      w(8'h01, 16'h0018);
      w(8'h00, 16'h0001);
      repeat (20) @(posedge clk);
      w(8'h00, 16'h0000);
      rc(8'h05, 16'h0002);
      w(8'h36, 16'h0009);
      rc(8'h05, 16'h0002);
      w(8'h38, 16'h0002);
      rc(8'h05, 16'h0000);
      w(8'h00, 16'h0001);
      repeat (20) @(posedge clk);
      w(8'h00, 16'h0000);
      rc(8'h28, 16'h0002);
      rc(8'h05, 16'h0002);
      $display("auto lock done");
      w(8'h00, 16'h0001);
      w(8'h05, 16'h000c);
      rc(8'h01, 16'h0018);
      w(8'h00, 16'h0000);
      w(8'h05, 16'h0008);
      rc(8'h20, 16'h0000);
      w(8'h05, 16'h000c);
      rc(8'h01, 16'h0000);
      rc(8'h26, 16'h0000);
      $display("command done");
      repeat (4) begin
         c1 = 16'($random(seed));
         w(8'h01, {9'h000, c1[2:0], 4'h0});
         w(8'h02, {13'h0000, c1[5:3]});
         repeat (3) @(posedge clk);
         `CK(logic_out, c1[5:3])
         `CK(pin_override, c1[2:0])
         `CK(pad_level & c1[2:0], c1[5:3] & c1[2:0])
      end
      w(8'h01, 16'h0070);
      w(8'h00, 16'h0001);
      repeat (3) @(posedge clk);
      `CK(pin_override, 3'h0)
      w(8'h01, 16'h0071);
      repeat (3) @(posedge clk);
      `CK(pin_override, 3'h7)
      w(8'h00, 16'h0000);
      $display("outputs done");
      w(8'h01, 16'h0000);
      w(8'h26, 16'h0302);
      w(8'h03, 16'h0001);
      w(8'h00, 16'h0001);
      r(8'h20, c1);
      // each byte steps down twice between reads, wrapping at its own period byte
      repeat (5) begin
         r(8'h20, c2);
         `CK(c2, {8'((c1[15:8] + 8'h2) % 8'h4), 8'((c1[7:0] + 8'h1) % 8'h3)})
         c1 = c2;
      end
      w(8'h00, 16'h0000);
      $display("split done");
      wrap_up();
   end
endmodule : timer_waveform_control_bench
